/* File: design/marker_pkg.sv */
package marker_pkg;

  localparam int MARKERS = 4;
  localparam int NUM_ENTRIES = 8;
  localparam int SLOT_W = 3;
  localparam int MARK_W = 2;
  localparam int IDX_W = 16;
  localparam int DLY_W = 8;
  localparam logic [DLY_W-1:0] MAX_DELAY = 8'hff;
  localparam logic [DLY_W-1:0] DELAY_RST = 8'h00;
  localparam logic [IDX_W-1:0] IDX_RST = 16'h0000;
  // sample path rate limit, and the rate this build is clocked at
  localparam int MEM_CLK_MAX_MHZ = 300;
  localparam int SYS_CLK_MHZ = 25;

  typedef logic [IDX_W-1:0] sampleIdx_t;
  typedef logic [DLY_W-1:0] delay_t;

  typedef enum logic [1:0] {
    MODE_UNCHANGED,
    MODE_LIST,
    MODE_OFF
  } markerMode_t;

  typedef struct packed {
    logic valid;
    sampleIdx_t first;
    sampleIdx_t last;
    logic value;
  } listEntry_t;

  typedef struct packed {
    logic [MARK_W-1:0] marker;
    logic [SLOT_W-1:0] slot;
    listEntry_t entry;
  } tableWrite_t;

  typedef struct packed {
    logic fixRange;
    delay_t rangeMin;
    delay_t rangeMax;
  } delayRange_t;

endpackage : marker_pkg

/* File: design/marker_delay_line.sv */
`timescale 1ns/1ns
`default_nettype none
module marker_delay_line (
  input wire logic clk,
  input wire logic rst,
  input wire logic shiftEn,
  input wire logic clear,
  input wire logic inBit,
  input wire marker_pkg::delay_t delay,
  output logic outBit
);
  import marker_pkg::*;

  localparam int HIST = int'(MAX_DELAY);

  logic [HIST-1:0] hist_q;
  logic [HIST:0] taps;
  logic tapBit;

  // tap 0 is the sample entering now, tap d is d samples old
  assign taps = {hist_q, inBit};
  assign tapBit = taps[delay]; // R4

  // delay is only a tap select, so a change acts at once, no restart
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      hist_q <= '0; // R10
      outBit <= 1'b0;
    end else if (shiftEn) begin
      hist_q <= {hist_q[HIST-2:0], inBit}; // R5
      outBit <= tapBit; // R8
    end
  end

  zeroDelay_a: assert property (@(posedge clk) disable iff (rst) // R4
    shiftEn && !clear && delay == 8'h00 |=> outBit == $past(inBit))
    else $error("zero delay does not pass the sample through");

  clearLow_a: assert property (@(posedge clk) disable iff (rst) // R10
    clear |=> !outBit && hist_q == '0)
    else $error("restart did not empty the delay history");

  oneDelay_a: assert property (@(posedge clk) disable iff (rst) // R5
    shiftEn && !clear && delay == 8'h01 |=> outBit == $past(hist_q[0]))
    else $error("delay of one sample picks the wrong tap");

  holdIdle_a: assert property (@(posedge clk) disable iff (rst) // R5
    !shiftEn && !clear |=> $stable(outBit))
    else $error("marker moved without a sample step");

endmodule : marker_delay_line
`default_nettype wire

/* File: design/marker_list_delay.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// [R1] list mode drives marker from 0/1 table
// [R2] range entries cover inclusive start to end
// [R3] single-sample entries, several entries in sequence
// [R4] each marker has its own delay
// [R5] delay counts samples, not time
// [R6] sample path pipelined for 300 MHz memory clock
// [R7] fixed range clamps accepted delays
// [R8] in-range delay change acts without restart
// [R9] mode selectable; file trace never overwritten
// [R10] uncovered samples low; table restarts at zero
module marker_list_delay (
  input wire logic clk,
  input wire logic rst,
  input wire logic sampleEn,
  input wire logic waveStart,
  input wire logic [marker_pkg::MARKERS-1:0] fileMarker,
  input wire marker_pkg::markerMode_t modeSel [marker_pkg::MARKERS],
  input wire logic tblWe,
  input wire marker_pkg::tableWrite_t tblWr,
  input wire logic [marker_pkg::MARKERS-1:0] delayWe,
  input wire marker_pkg::delay_t delayVal,
  input wire marker_pkg::delayRange_t delayRange,
  output logic [marker_pkg::MARKERS-1:0] markerOut,
  output marker_pkg::sampleIdx_t sampleIdx,
  output marker_pkg::delay_t delayOut [marker_pkg::MARKERS]
);
  import marker_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // later entries override earlier ones; nothing covered reads low
  function automatic logic listLookup(input listEntry_t ents [NUM_ENTRIES], input sampleIdx_t idx);
    logic bitVal;
    bitVal = 1'b0; // R10
    for (int e = 0; e < NUM_ENTRIES; e++) begin
      if (ents[e].valid && idx >= ents[e].first && idx <= ents[e].last) begin // R2 R3
        bitVal = ents[e].value;
      end
    end
    return bitVal;
  endfunction : listLookup

  function automatic delay_t acceptDelay(input delay_t v, input delayRange_t r);
    delay_t res;
    res = v;
    if (r.fixRange) begin
      if (v < r.rangeMin) begin
        res = r.rangeMin; // R7
      end else if (v > r.rangeMax) begin
        res = r.rangeMax; // R7
      end
    end
    return res;
  endfunction : acceptDelay

  ////////////////////////////////////////////////////////////////////////////
  // sample index

  listEntry_t table_q [MARKERS][NUM_ENTRIES];
  delay_t delay_q [MARKERS];
  sampleIdx_t idx_q;
  logic restart_q;
  logic step_q;
  logic [MARKERS-1:0] srcBit;
  logic [MARKERS-1:0] listBit;
  logic [MARKERS-1:0] src_q;

  assign sampleIdx = idx_q;

  always_ff @(posedge clk) begin
    if (rst || waveStart) begin
      idx_q <= IDX_RST; // R10
    end else if (sampleEn) begin
      idx_q <= idx_q + 16'h0001; // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // list table

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int m = 0; m < MARKERS; m++) begin
        for (int e = 0; e < NUM_ENTRIES; e++) begin
          table_q[m][e] <= '0;
        end
      end
    end else if (tblWe) begin
      table_q[tblWr.marker][tblWr.slot] <= tblWr.entry; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay settings

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int m = 0; m < MARKERS; m++) begin
        delay_q[m] <= DELAY_RST;
      end
    end else begin
      for (int m = 0; m < MARKERS; m++) begin
        if (delayWe[m]) begin
          delay_q[m] <= acceptDelay(delayVal, delayRange); // R4 R7
        end
      end
    end
  end

  assign delayOut = delay_q;

  ////////////////////////////////////////////////////////////////////////////
  // per-marker source select and delay

  // the file trace is only read, a mode choice never writes it back
  genvar g;
  generate
    for (g = 0; g < MARKERS; g++) begin : gMark
      assign listBit[g] = listLookup(table_q[g], idx_q); // R1
      assign srcBit[g] = (modeSel[g] == MODE_LIST) ? listBit[g] :
                         (modeSel[g] == MODE_UNCHANGED) ? fileMarker[g] : 1'b0; // R9

      marker_delay_line uDelay (
        .clk(clk),
        .rst(rst),
        .shiftEn(step_q),
        .clear(restart_q),
        .inBit(src_q[g]),
        .delay(delay_q[g]),
        .outBit(markerOut[g])
      );
    end
  endgenerate

  // one register stage between table compare and delay taps
  always_ff @(posedge clk) begin
    if (rst) begin
      src_q <= '0;
      step_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      src_q <= srcBit; // R6
      step_q <= sampleEn && !waveStart; // R6
      restart_q <= waveStart;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  idxRestart_a: assert property (@(posedge clk) disable iff (rst) // R10
    waveStart |=> idx_q == 16'h0000)
    else $error("waveform restart did not return index to zero");

  idxStep_a: assert property (@(posedge clk) disable iff (rst) // R5
    sampleEn && !waveStart |=> idx_q == $past(idx_q) + 16'h0001)
    else $error("sample index did not advance by one");

  idxHold_a: assert property (@(posedge clk) disable iff (rst) // R5
    !sampleEn && !waveStart |=> $stable(idx_q))
    else $error("sample index moved without a sample step");

  delayOwn_a: assert property (@(posedge clk) disable iff (rst) // R4
    !delayWe[1] && delayWe[0] |=> $stable(delay_q[1]))
    else $error("marker 2 delay changed on a marker 1 write");

  delayClamp_a: assert property (@(posedge clk) disable iff (rst) // R7
    delayWe[0] && delayRange.fixRange && delayRange.rangeMin <= delayRange.rangeMax
    |=> delay_q[0] >= $past(delayRange.rangeMin) && delay_q[0] <= $past(delayRange.rangeMax))
    else $error("accepted delay left the fixed range");

  delayFree_a: assert property (@(posedge clk) disable iff (rst) // R8
    delayWe[0] && !delayRange.fixRange && !waveStart |=> delay_q[0] == $past(delayVal) && !restart_q)
    else $error("free delay write not taken as given");

  listSel_a: assert property (@(posedge clk) disable iff (rst) // R1
    modeSel[0] == MODE_LIST |-> srcBit[0] == listBit[0])
    else $error("list mode does not follow the table");

  fileSel_a: assert property (@(posedge clk) disable iff (rst) // R9
    modeSel[0] == MODE_UNCHANGED |-> srcBit[0] == fileMarker[0])
    else $error("unchanged mode does not follow the file trace");

  offLow_a: assert property (@(posedge clk) disable iff (rst) // R9
    modeSel[2] == MODE_OFF |-> !srcBit[2])
    else $error("off mode does not drive low");

  tableWr_a: assert property (@(posedge clk) disable iff (rst) // R3
    tblWe |=> table_q[$past(tblWr.marker)][$past(tblWr.slot)] == $past(tblWr.entry))
    else $error("table entry not stored");

  emptyLow_a: assert property (@(posedge clk) disable iff (rst) // R10
    !table_q[0][0].valid && !table_q[0][1].valid && !table_q[0][2].valid && !table_q[0][3].valid &&
    !table_q[0][4].valid && !table_q[0][5].valid && !table_q[0][6].valid && !table_q[0][7].valid
    |-> !listBit[0])
    else $error("empty table does not read low");

  rangeHit_a: assert property (@(posedge clk) disable iff (rst) // R2
    table_q[MARKERS-1][NUM_ENTRIES-1].valid &&
    idx_q >= table_q[MARKERS-1][NUM_ENTRIES-1].first &&
    idx_q <= table_q[MARKERS-1][NUM_ENTRIES-1].last
    |-> listBit[MARKERS-1] == table_q[MARKERS-1][NUM_ENTRIES-1].value)
    else $error("last matching range entry not applied");

  pipeStep_a: assert property (@(posedge clk) disable iff (rst) // R6
    sampleEn && !waveStart |=> step_q && src_q == $past(srcBit))
    else $error("sample stage did not capture the source bits");

endmodule : marker_list_delay
`default_nettype wire

/* File: tb/marker_list_delay_test.sv */
`timescale 1ns/1ns
`default_nettype none
module marker_list_delay_test;
  import marker_pkg::*;
  logic clk = 0, rst = 1, sampleEn = 0, waveStart = 0, tblWe = 0;
  logic [MARKERS-1:0] fileMarker = '0, delayWe = '0, markerOut;
  markerMode_t modeSel [MARKERS];
  tableWrite_t tblWr = '0;
  delay_t delayVal = '0;
  delay_t delayOut [MARKERS];
  delay_t dly [MARKERS];
  delayRange_t delayRange = '0;
  sampleIdx_t sampleIdx;
  listEntry_t tbl [MARKERS][NUM_ENTRIES];
  logic hist [MARKERS][$];
  int error_cnt = 0, n_compared = 0, idx = 0;

  marker_list_delay DUT (.clk(clk), .rst(rst), .sampleEn(sampleEn), .waveStart(waveStart),
    .fileMarker(fileMarker), .modeSel(modeSel), .tblWe(tblWe), .tblWr(tblWr), .delayWe(delayWe),
    .delayVal(delayVal), .delayRange(delayRange), .markerOut(markerOut), .sampleIdx(sampleIdx),
    .delayOut(delayOut));

  always #20 clk = ~clk;

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic listEntry_t ent(input int f, input int l, input logic v);
    return '{1'b1, IDX_W'(f), IDX_W'(l), v};
  endfunction : ent

  // expected source bit, higher slot wins
  function automatic logic srcBit(input int m, input int i);
    logic b;
    b = 1'b0;
    if (modeSel[m] == MODE_UNCHANGED) b = fileMarker[m];
    else if (modeSel[m] == MODE_LIST)
      for (int s = 0; s < NUM_ENTRIES; s++)
        if (tbl[m][s].valid && i >= tbl[m][s].first && i <= tbl[m][s].last) b = tbl[m][s].value;
    return b;
  endfunction : srcBit

  task automatic wrEntry(input int m, input int s, input listEntry_t e);
    @(negedge clk);
    tblWe = 1;
    tblWr = '{m[1:0], s[2:0], e};
    tbl[m][s] = e;
    @(negedge clk);
    tblWe = 0;
  endtask : wrEntry

  task automatic setDelay(input int m, input delay_t v);
    @(negedge clk);
    delayVal = v;
    delayWe = 4'h1 << m;
    dly[m] = !delayRange.fixRange ? v : v < delayRange.rangeMin ? delayRange.rangeMin :
      v > delayRange.rangeMax ? delayRange.rangeMax : v;
    @(negedge clk);
    delayWe = '0;
    chk(delayOut[m], dly[m], "accepted delay");
  endtask : setDelay

  task automatic step(input int n);
    repeat (n) begin
      @(negedge clk);
      fileMarker = MARKERS'($urandom);
      sampleEn = 1;
      for (int m = 0; m < MARKERS; m++) hist[m].push_back(srcBit(m, idx));
      @(negedge clk);
      sampleEn = 0;
      idx++;
      chk(sampleIdx, idx, "sample index");
      @(negedge clk);
      for (int m = 0; m < MARKERS; m++)
        chk(markerOut[m], idx > dly[m] ? hist[m][idx-1-dly[m]] : 1'b0, "marker");
    end
  endtask : step

  // restart, optionally colliding with a sample step
  task automatic restart(input logic se);
    @(negedge clk);
    waveStart = 1;
    sampleEn = se;
    @(negedge clk);
    waveStart = 0;
    sampleEn = 0;
    @(negedge clk);
    idx = 0;
    for (int m = 0; m < MARKERS; m++) hist[m].delete();
    chk(sampleIdx, 0, "restart index");
    chk(markerOut, 0, "restart marker");
  endtask : restart

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////
  initial begin
    for (int m = 0; m < MARKERS; m++) begin
      modeSel[m] = MODE_LIST;
      dly[m] = '0;
      for (int s = 0; s < NUM_ENTRIES; s++) tbl[m][s] = '0;
    end
    void'($urandom(32'he8ab89af));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 0;
    chk(sampleIdx, 0, "reset index");
    chk(markerOut, 0, "reset marker");
    for (int m = 0; m < MARKERS; m++) chk(delayOut[m], 0, "reset delay");
    $display("test reset done");
    modeSel[1] = MODE_UNCHANGED;
    modeSel[2] = MODE_OFF;
    wrEntry(0, 0, ent(3, 6, 1'b1));
    wrEntry(0, 1, ent(8, 8, 1'b1));
    wrEntry(0, 2, ent(5, 5, 1'b0));
    wrEntry(0, 3, ent(12, 10, 1'b1));
    for (int s = 0; s < NUM_ENTRIES; s++) begin
      idx = $urandom % 20;
      wrEntry(3, s, ent(idx, idx + $urandom % 6, 1'($urandom)));
    end
    restart(1'b0);
    step(24);
    $display("test list table done");
    for (int m = 0; m < MARKERS; m++) setDelay(m, delay_t'($urandom % 10));
    restart(1'b0);
    step(20);
    modeSel[2] = MODE_UNCHANGED;
    for (int m = 0; m < MARKERS; m++) setDelay(m, delay_t'($urandom % 10));
    step(12);
    $display("test delay done");
    delayRange = '{1'b1, 8'h02, 8'h05};
    setDelay(0, 8'h00);
    setDelay(1, 8'h06);
    setDelay(2, 8'h02);
    setDelay(3, 8'hff);
    step(10);
    restart(1'b1);
    step(8);
    $display("test range and restart done");
    complete_run();
  end

  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule : marker_list_delay_test
`default_nettype wire
